// File: verilog/cwp_guard.sv
// Contract
// - A tier read returns 0x00 to 0x03 for none, shared, user, vendor.
// - The tier command is a one-byte read only; writes are refused.
// - Writes are gated per command by mask bits; reads always pass. Here codes 0xfa to 0xfd ignore their mask bits and follow their own rules.
// - A non-writable command changes only after a valid key is accepted.
// - An accepted store key makes masked commands changeable.
// - Factory and user stores keep separate masks and secret keys.
// - A factory-mask cleared bit needs the factory key before writes.
// - Factory-writable, user-cleared commands open with the user key.
// - The user key command is a nine-byte read/write block.
// - Keys are ASCII strings formatted like maker_ident_string.
// - The shared lock key command is a four-byte read/write block.
// - The mask is 256 bits moved as a 32-byte read/write block.
// - Mask bit n, byte n/8 bit n%8, belongs to command code n.
// - Every code has a mask bit, supported or not.
// - A cleared bit blocks writes until the tier is high enough.
// - The factory mask is writable only at tier 3 or above.
// - The user mask is writable only at tier 2 or above.
//
// Protection core of a management-bus device. A transfer decoder in front of it hands over
// command code, data bytes and stop on the same clock; no pin is sampled here.
// Factory mask and factory key arrive from nonvolatile storage as inputs.
`timescale 1ns/1ps
`include "cwp_regs.svh"

module cwp_guard #(
	parameter int USER_KEY_BYTES = 9,
	parameter int LOCK_KEY_BYTES = 4,
	parameter int MASK_BYTES     = 32
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	input  wire cwp_pkg::cwp_req_t     req,
	input  wire logic [255:0]          factory_mask,
	input  wire logic [71:0]           factory_key,
	input  wire logic [31:0]           lock_key_expect,
	input  wire logic                  store_sel_user,
	output cwp_pkg::cwp_rsp_t          rsp,
	output logic [1:0]                 tier,
	output logic [255:0]               user_mask,
	output logic                       wr_commit,
	output logic [7:0]                 wr_commit_code
);
	if (USER_KEY_BYTES != 9 || LOCK_KEY_BYTES != 4 || MASK_BYTES != 32) begin : g_len_check
		$error("cwp_guard: block lengths other than 9, 4 and 32 bytes are not served");
	end

	cwp_pkg::cwp_state_t state_reg;
	logic [7:0]   code_reg;
	logic         wr_reg;
	logic [5:0]   cnt_reg;
	logic [255:0] shift_reg;
	logic [1:0]   tier_reg;
	logic [255:0] user_mask_reg;
	logic [255:0] fmask_shadow_reg;
	logic [71:0]  user_key_reg;
	logic [31:0]  lock_key_reg;
	logic         allowed_reg;
	logic [7:0]   rd_byte_reg;
	logic         rd_valid_reg;
	logic         refused_reg;
	logic         commit_reg;
	logic [7:0]   commit_code_reg;

	logic [5:0]   exp_len;
	logic         len_ok;
	logic         cmd_writable;
	logic         is_special;
	logic [255:0] rd_image;
	logic         judge;

	// Expected block length of each special command.
	always_comb begin
		case (code_reg)
			`CWP_CMD_TIER:     exp_len = `CWP_LEN_TIER;
			`CWP_CMD_USER_KEY: exp_len = `CWP_LEN_USER_KEY;
			`CWP_CMD_LOCK_KEY: exp_len = `CWP_LEN_LOCK_KEY;
			`CWP_CMD_MASK:     exp_len = `CWP_LEN_MASK;
			default:           exp_len = 6'h00;
		endcase
	end

	assign is_special = (code_reg >= `CWP_CMD_TIER) && (code_reg <= `CWP_CMD_MASK);
	assign len_ok     = (cnt_reg == exp_len);
	// The enabled edge at which a write transfer ends and is judged.
	assign judge      = clk_en && (state_reg == cwp_pkg::CWP_ST_DATA) && req.stop && wr_reg;

	// The factory mask bit dominates; the user mask only narrows further.
	always_comb begin
		if (!factory_mask[code_reg])
			cmd_writable = (tier_reg >= `CWP_TIER_VENDOR);
		else if (!user_mask_reg[code_reg])
			cmd_writable = (tier_reg >= `CWP_TIER_USER);
		else
			cmd_writable = 1'b1;
	end

	// Read image of the addressed command, least significant byte first.
	always_comb begin
		case (code_reg)
			`CWP_CMD_TIER:     rd_image = {254'h0, tier_reg};
			`CWP_CMD_USER_KEY: rd_image = {184'h0, user_key_reg};
			`CWP_CMD_LOCK_KEY: rd_image = {224'h0, lock_key_reg};
			`CWP_CMD_MASK:     rd_image = store_sel_user ? user_mask_reg : factory_mask;
			default:           rd_image = 256'h0;
		endcase
	end

	// Transfer sequencing.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= cwp_pkg::CWP_ST_IDLE;
			code_reg  <= 8'h00;
			wr_reg    <= 1'b0;
			cnt_reg   <= 6'h00;
			shift_reg <= 256'h0;
		end else if (clk_en) begin
			case (state_reg)
				cwp_pkg::CWP_ST_IDLE: begin
					if (req.start) begin
						state_reg <= cwp_pkg::CWP_ST_DATA;
						code_reg  <= req.code;
						wr_reg    <= req.wr;
						cnt_reg   <= 6'h00;
						shift_reg <= 256'h0;
					end
				end
				cwp_pkg::CWP_ST_DATA: begin
					if (req.stop) begin
						state_reg <= cwp_pkg::CWP_ST_DONE;
					end else if (wr_reg && req.byte_valid && cnt_reg != 6'h3f) begin
						shift_reg <= shift_reg | ({248'h0, req.byte_data} << {cnt_reg, 3'h0});
						cnt_reg   <= cnt_reg + 6'h01;
					end else if (!wr_reg && req.rd_ack && cnt_reg != 6'h3f) begin
						cnt_reg <= cnt_reg + 6'h01;
					end
				end
				cwp_pkg::CWP_ST_DONE: state_reg <= cwp_pkg::CWP_ST_IDLE;
				default:              state_reg <= cwp_pkg::CWP_ST_IDLE;
			endcase
		end
	end

	// Read data path; the four special commands stay readable whatever their mask bits, other codes get no read data here.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_byte_reg  <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else if (clk_en) begin
			rd_valid_reg <= (state_reg == cwp_pkg::CWP_ST_DATA) && !wr_reg && is_special;
			rd_byte_reg  <= rd_image[{cnt_reg[4:0], 3'h0} +: 8];
		end
	end

	// Commit at stop: stores, key checks and the write verdict for other commands.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tier_reg        <= `CWP_TIER_NONE;
			user_mask_reg   <= `CWP_MASK_RESET;
			fmask_shadow_reg <= `CWP_MASK_RESET;
			user_key_reg    <= `CWP_USER_KEY_RST;
			lock_key_reg    <= `CWP_LOCK_KEY_RST;
			refused_reg     <= 1'b0;
			commit_reg      <= 1'b0;
			commit_code_reg <= 8'h00;
		end else if (clk_en) begin
			refused_reg <= 1'b0;
			commit_reg  <= 1'b0;
			if (state_reg == cwp_pkg::CWP_ST_DATA && req.stop && wr_reg) begin
				commit_code_reg <= code_reg;
				case (code_reg)
					`CWP_CMD_TIER: refused_reg <= 1'b1;
					`CWP_CMD_LOCK_KEY: begin
						if (!len_ok)
							refused_reg <= 1'b1;
						else if (shift_reg[31:0] == lock_key_expect) begin
							lock_key_reg <= shift_reg[31:0];
							if (tier_reg < `CWP_TIER_SHARED)
								tier_reg <= `CWP_TIER_SHARED;
						end else
							refused_reg <= 1'b1;
					end
					`CWP_CMD_USER_KEY: begin
						// Factory key wins if both match, since it opens more.
						if (!len_ok)
							refused_reg <= 1'b1;
						else if (shift_reg[71:0] == factory_key)
							tier_reg <= `CWP_TIER_VENDOR;
						else if (shift_reg[71:0] == user_key_reg) begin
							if (tier_reg < `CWP_TIER_USER)
								tier_reg <= `CWP_TIER_USER;
						end else if (tier_reg >= `CWP_TIER_USER)
							user_key_reg <= shift_reg[71:0];
						else
							refused_reg <= 1'b1;
					end
					`CWP_CMD_MASK: begin
						if (!len_ok)
							refused_reg <= 1'b1;
						else if (store_sel_user && tier_reg >= `CWP_TIER_USER)
							user_mask_reg <= shift_reg;
						else if (!store_sel_user && tier_reg >= `CWP_TIER_VENDOR)
							fmask_shadow_reg <= shift_reg;
						else
							refused_reg <= 1'b1;
					end
					default: begin
						if (cmd_writable)
							commit_reg <= 1'b1;
						else
							refused_reg <= 1'b1;
					end
				endcase
			end
		end
	end

	// The writable verdict is held for the decoder while bytes arrive.
	// Special commands are judged by their own rules at stop, so the flag stays high for them.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			allowed_reg <= 1'b1;
		else if (clk_en)
			allowed_reg <= cmd_writable || is_special;
	end

	assign rsp            = {rd_valid_reg, rd_byte_reg, allowed_reg, refused_reg};
	assign tier           = tier_reg;
	assign user_mask      = user_mask_reg;
	assign wr_commit      = commit_reg;
	assign wr_commit_code = commit_code_reg;

	AST_TIER_WRITE_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state_reg == cwp_pkg::CWP_ST_DATA && req.stop && wr_reg
		&& code_reg == `CWP_CMD_TIER |=> refused_reg && $stable(tier_reg))
		else $error("Tier write was not refused.");

	AST_TIER_MISMATCH: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state_reg == cwp_pkg::CWP_ST_DATA && req.stop && wr_reg
		&& code_reg == `CWP_CMD_LOCK_KEY && shift_reg[31:0] != lock_key_expect
		|=> $stable(tier_reg))
		else $error("Tier moved on a key mismatch.");

	AST_LOCK_RAISE: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state_reg == cwp_pkg::CWP_ST_DATA && req.stop && wr_reg && len_ok
		&& code_reg == `CWP_CMD_LOCK_KEY && shift_reg[31:0] == lock_key_expect
		|=> tier_reg >= `CWP_TIER_SHARED)
		else $error("Matching lock key did not raise the tier.");

	AST_USER_MASK_GUARD: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(user_mask_reg) |-> $past(tier_reg) >= `CWP_TIER_USER)
		else $error("User mask changed below tier 2.");

	AST_FACT_MASK_GUARD: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(fmask_shadow_reg) |-> $past(tier_reg) == `CWP_TIER_VENDOR)
		else $error("Factory mask changed below tier 3.");

	AST_FACTORY_GATE: assert property (@(posedge clk) disable iff (!rst_n)
		commit_reg && !$past(factory_mask[code_reg]) |-> $past(tier_reg) == `CWP_TIER_VENDOR)
		else $error("Factory-protected command committed without vendor tier.");

	AST_USER_GATE: assert property (@(posedge clk) disable iff (!rst_n)
		commit_reg && !$past(user_mask_reg[code_reg]) |-> $past(tier_reg) >= `CWP_TIER_USER)
		else $error("User-protected command committed below tier 2.");

	AST_REFUSE_NO_COMMIT: assert property (@(posedge clk) disable iff (!rst_n)
		refused_reg |-> !commit_reg && $stable(user_key_reg))
		else $error("Refused write changed state.");

	AST_READ_ALWAYS: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state_reg == cwp_pkg::CWP_ST_DATA && !wr_reg && is_special |=> rd_valid_reg)
		else $error("Read of a protected command was withheld.");

	AST_LEN_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
		judge && is_special && code_reg != `CWP_CMD_TIER && !len_ok |=> refused_reg)
		else $error("Block of wrong length was not refused.");

	AST_FACTORY_KEY: assert property (@(posedge clk) disable iff (!rst_n)
		judge && len_ok && code_reg == `CWP_CMD_USER_KEY && shift_reg[71:0] == factory_key
		|=> tier_reg == `CWP_TIER_VENDOR)
		else $error("Factory key did not raise the tier to 3.");

	AST_USER_KEY_RAISE: assert property (@(posedge clk) disable iff (!rst_n)
		judge && len_ok && code_reg == `CWP_CMD_USER_KEY && shift_reg[71:0] == user_key_reg
		|=> tier_reg >= `CWP_TIER_USER)
		else $error("Stored user key did not raise the tier to 2.");

	AST_TIER_MONOTONIC: assert property (@(posedge clk) disable iff (!rst_n)
		tier_reg >= $past(tier_reg))
		else $error("Tier fell without a reset.");

	AST_PROTECTED_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
		judge && !is_special && !cmd_writable |=> refused_reg && !commit_reg)
		else $error("Protected command write was not refused.");

	AST_WRITABLE_COMMIT: assert property (@(posedge clk) disable iff (!rst_n)
		judge && !is_special && cmd_writable
		|=> commit_reg && commit_code_reg == $past(code_reg))
		else $error("Writable command was not committed with its code.");

	AST_COMMIT_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		commit_reg && clk_en |=> !commit_reg)
		else $error("Commit strobe stood longer than one cycle.");

	AST_TIER_READ_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state_reg == cwp_pkg::CWP_ST_DATA && !wr_reg && code_reg == `CWP_CMD_TIER
		&& cnt_reg == 6'h00 |=> rd_byte_reg == {6'h00, $past(tier_reg)})
		else $error("Tier read returned a value other than the tier.");

	AST_USER_KEY_GUARD: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(user_key_reg) |-> $past(tier_reg) >= `CWP_TIER_USER)
		else $error("User key changed below tier 2.");

	AST_LOCK_KEY_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(lock_key_reg) |-> lock_key_reg == $past(lock_key_expect))
		else $error("Stored lock key differs from the expected key.");

	AST_MASK_REFUSE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		judge && len_ok && code_reg == `CWP_CMD_MASK && store_sel_user
		&& tier_reg < `CWP_TIER_USER |=> refused_reg && $stable(user_mask_reg))
		else $error("User mask write below tier 2 was not refused.");

	AST_FMASK_REFUSE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		judge && len_ok && code_reg == `CWP_CMD_MASK && !store_sel_user
		&& tier_reg < `CWP_TIER_VENDOR |=> refused_reg && $stable(fmask_shadow_reg))
		else $error("Factory mask write below tier 3 was not refused.");

	AST_REFUSE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		refused_reg && clk_en |=> !refused_reg)
		else $error("Refusal pulse stood longer than one cycle.");

	COV_LOCK_ACCEPT: cover property (@(posedge clk) disable iff (!rst_n)
		tier_reg == `CWP_TIER_NONE ##1 tier_reg == `CWP_TIER_SHARED);
	COV_VENDOR: cover property (@(posedge clk) disable iff (!rst_n)
		tier_reg == `CWP_TIER_VENDOR);
	COV_REFUSE: cover property (@(posedge clk) disable iff (!rst_n) refused_reg);
	COV_COMMIT: cover property (@(posedge clk) disable iff (!rst_n) commit_reg);
	COV_MASK_READ: cover property (@(posedge clk) disable iff (!rst_n)
		rd_valid_reg && code_reg == `CWP_CMD_MASK);
endmodule

// File: verilog/cwp_regs.svh
// Command codes, field widths, reset values and tier encodings for the command write protection block.
// Assumes the includer compiles it once per unit. The guard below prevents a second inclusion.
`ifndef CWP_REGS_SVH
`define CWP_REGS_SVH
`define CWP_CMD_TIER      8'hfa
`define CWP_CMD_USER_KEY  8'hfb
`define CWP_CMD_LOCK_KEY  8'hfc
`define CWP_CMD_MASK      8'hfd
`define CWP_TIER_NONE     2'h0
`define CWP_TIER_SHARED   2'h1
`define CWP_TIER_USER     2'h2
`define CWP_TIER_VENDOR   2'h3
`define CWP_LEN_TIER      6'h01
`define CWP_LEN_USER_KEY  6'h09
`define CWP_LEN_LOCK_KEY  6'h04
`define CWP_LEN_MASK      6'h20
`define CWP_MASK_RESET    256'h0
`define CWP_USER_KEY_RST  72'h0
`define CWP_LOCK_KEY_RST  32'h0
`endif

// File: verilog/cwp_pkg.sv
// Types shared by the command write protection block.
// Assumes cwp_regs.svh supplies all numeric constants except the state encodings below.
package cwp_pkg;
	typedef enum logic [1:0] {
		CWP_ST_IDLE = 2'h0,
		CWP_ST_DATA = 2'h1,
		CWP_ST_DONE = 2'h3
	} cwp_state_t;

	typedef struct packed {
		logic       start;
		logic       wr;
		logic [7:0] code;
		logic       byte_valid;
		logic [7:0] byte_data;
		logic       stop;
		logic       rd_ack;
	} cwp_req_t;

	typedef struct packed {
		logic       rd_valid;
		logic [7:0] rd_data;
		logic       wr_allowed;
		logic       refused;
	} cwp_rsp_t;
endpackage

// File: verif/cwp_host.sv
// Host model: issues whole command transfers to the protection core, one at a time.
// Assumes the core takes requests on rising clk with clk_en held high.
`timescale 1ns/1ps
module cwp_host (
	input  wire logic              clk,
	output cwp_pkg::cwp_req_t      req,
	input  wire cwp_pkg::cwp_rsp_t rsp
);
	initial req = '0;

	// Start, bytes, stop, then idle cycles so the next start never lands in the done state.
	task automatic xfer(input logic wr, input logic [7:0] code, input int n,
		input logic [255:0] d, output logic ref_seen, output logic [255:0] rd);
		int i;
		int k;
		rd = '0;
		@(posedge clk);
		req.start <= 1'b1;
		req.wr    <= wr;
		req.code  <= code;
		@(posedge clk);
		req.start <= 1'b0;
		for (i = 0; i < n; i++) begin
			if (wr) begin
				// The strobe stays up across back-to-back bytes; one new byte per edge.
				req.byte_valid <= 1'b1;
				req.byte_data  <= d[8*i +: 8];
				@(posedge clk);
			end else begin
				// Read data trails each data-state edge by a cycle, so two edges pass first.
				k = 0;
				repeat (2) @(posedge clk);
				while (rsp.rd_valid !== 1'b1 && k < 8) begin
					@(posedge clk);
					k++;
				end
				rd[8*i +: 8] = rsp.rd_data;
				req.rd_ack <= 1'b1;
				@(posedge clk);
				req.rd_ack <= 1'b0;
			end
		end
		if (wr && n > 0) begin
			req.byte_valid <= 1'b0;
			// Released data lines must not keep showing the last byte.
			req.byte_data  <= ~d[8*(n-1) +: 8];
		end
		req.stop <= 1'b1;
		@(posedge clk);
		req.stop <= 1'b0;
		ref_seen = 1'b0;
		repeat (3) begin
			@(posedge clk);
			ref_seen = ref_seen | (rsp.refused === 1'b1);
		end
	endtask
endmodule

// File: verif/cwp_guard_bench.sv
// Self-checking bench for the protection core: key entry, tier reads, mask writes, gated writes.
// Assumes cwp_host drives every transfer; storage inputs are driven here.
`timescale 1ns/1ps
`include "cwp_regs.svh"
module cwp_guard_bench;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	cwp_pkg::cwp_req_t req;
	cwp_pkg::cwp_rsp_t rsp;
	logic [255:0]      fmask = 256'h1 << 8'h22;
	logic [71:0]       fkey = 72'h66_61_63_74_6b_65_79_30_31;
	logic [31:0]       lkey = 32'h6b_65_79_31;
	logic              sel_user = 1'b1;
	logic [1:0]        tier;
	logic [255:0]      user_mask;
	logic              wr_commit;
	logic [7:0]        wr_commit_code;
	logic [71:0]       ukey = 72'h75_73_65_72_6b_65_79_30_31;
	logic              en = 1'b1;
	int                cm_cnt = 0;
	logic [7:0]        cm_code = 8'h00;
	logic              rf;
	logic [255:0]      rdb;
	int                err_total = 0;
	int                checked = 0;
	int                cyc = 0;

	always #5 clk = ~clk;

	cwp_guard u_cwp_guard (
		.clk            (clk),
		.rst_n          (rst_n),
		.clk_en         (en),
		.req            (req),
		.factory_mask   (fmask),
		.factory_key    (fkey),
		.lock_key_expect(lkey),
		.store_sel_user (sel_user),
		.rsp            (rsp),
		.tier           (tier),
		.user_mask      (user_mask),
		.wr_commit      (wr_commit),
		.wr_commit_code (wr_commit_code)
	);

	cwp_host u_cwp_host (.clk(clk), .req(req), .rsp(rsp));

	always @(posedge clk) begin
		if (wr_commit === 1'b1) begin
			cm_cnt  <= cm_cnt + 1;
			cm_code <= wr_commit_code;
		end
		cyc++;
		if (cyc >= 5000) begin
			err_total++;
			$display("Error cycle_limit expected below %0d seen %0d", 5000, cyc);
			final_report();
		end
	end

	task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// For codes below 0xfa, a refused write must also leave the commit strobe quiet; an allowed one commits its code.
	task automatic wr(input logic [7:0] code, input int n, input logic [255:0] d,
		input logic exp_ref);
		int c0;
		c0 = cm_cnt;
		u_cwp_host.xfer(1'b1, code, n, d, rf, rdb);
		chk("refused", exp_ref, rf);
		if (code < 8'hfa) begin
			chk("commit_count", exp_ref ? 256'h0 : 256'h1, cm_cnt - c0);
			if (!exp_ref) chk("commit_code", code, cm_code);
		end
	endtask

	task automatic rd_tier(input logic [7:0] exp);
		u_cwp_host.xfer(1'b0, `CWP_CMD_TIER, 1, 256'h0, rf, rdb);
		chk("tier_read", exp, rdb);
		chk("tier_port", exp, tier);
	endtask

	// Reads are never refused, whatever the tier.
	task automatic rd_chk(input string name, input logic [7:0] code, input int n,
		input logic [255:0] exp);
		u_cwp_host.xfer(1'b0, code, n, 256'h0, rf, rdb);
		chk("read_refused", 256'h0, rf);
		chk(name, exp, rdb);
	endtask

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd_tier(8'h00);
		chk("user_mask", 256'h0, user_mask);
		en <= 1'b0;
		wr(`CWP_CMD_LOCK_KEY, 4, {224'h0, lkey}, 1'b0);
		chk("tier_frozen", 256'h0, tier);
		en <= 1'b1;
		wr(`CWP_CMD_TIER, 1, 256'h03, 1'b1);
		rd_tier(8'h00);
		wr(8'h22, 1, 256'h55, 1'b1);
		chk("wr_allowed", 256'h0, rsp.wr_allowed);
		wr(`CWP_CMD_LOCK_KEY, 4, 256'h6b_65_79_32, 1'b1);
		rd_tier(8'h00);
		wr(`CWP_CMD_LOCK_KEY, 3, 256'h65_79_31, 1'b1);
		wr(`CWP_CMD_LOCK_KEY, 4, {224'h0, lkey}, 1'b0);
		rd_tier(8'h01);
		rd_chk("lock_key_read", `CWP_CMD_LOCK_KEY, 4, {224'h0, lkey});
		wr(`CWP_CMD_MASK, 32, 256'h1 << 8'h21, 1'b1);
		chk("user_mask", 256'h0, user_mask);
		wr(`CWP_CMD_USER_KEY, 9, 256'h0, 1'b0);
		rd_tier(8'h02);
		wr(8'h22, 1, 256'h55, 1'b0);
		chk("wr_allowed", 256'h1, rsp.wr_allowed);
		wr(8'h21, 1, 256'h55, 1'b1);
		wr(`CWP_CMD_USER_KEY, 9, {184'h0, ukey}, 1'b0);
		rd_chk("user_key_read", `CWP_CMD_USER_KEY, 9, {184'h0, ukey});
		rd_tier(8'h02);
		sel_user <= 1'b0;
		wr(`CWP_CMD_MASK, 32, 256'h1 << 8'h21, 1'b1);
		sel_user <= 1'b1;
		wr(`CWP_CMD_MASK, 31, 256'h1 << 8'h21, 1'b1);
		wr(`CWP_CMD_MASK, 32, (256'h1 << 8'h21) | (256'h1 << 8'hfd), 1'b0);
		chk("user_mask", (256'h1 << 8'h21) | (256'h1 << 8'hfd), user_mask);
		rd_chk("mask_read", `CWP_CMD_MASK, 32, (256'h1 << 8'h21) | (256'h1 << 8'hfd));
		wr(`CWP_CMD_USER_KEY, 9, {184'h0, fkey}, 1'b0);
		rd_tier(8'h03);
		wr(8'h21, 1, 256'haa, 1'b0);
		sel_user <= 1'b0;
		wr(`CWP_CMD_MASK, 32, 256'h1 << 8'h21, 1'b0);
		final_report();
	end
endmodule
